// ### common/timer_pkg.sv
// constants shared by the reload timer and its helpers
// assumes a 32-bit AXI4-Lite register bus and one system clock
package timer_pkg;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int CNT_W = 16;
    // prescale select: divide by 2**sel, sel 0..7 gives 1..128
    localparam int PRE_W = 3;
    localparam int DIV_W = 7;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_RELOAD = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    // control register fields
    localparam int CTRL_W = 7;
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_PRE_LO = 2;
    localparam int CTRL_POL = 5;
    localparam int CTRL_OUTEN = 6;
    // status register fields
    localparam int STAT_SEEN = 0;
    localparam int STAT_RUN = 1;
    // reset and restart values
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] RELOAD_RST = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_RESTART = 16'h0001;
    localparam logic [CNT_W-1:0] COUNT_STEP = 16'h0001;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic {
        MODE_ONESHOT = 1'b0,
        MODE_CONT = 1'b1
    } mode_e;
    typedef enum logic [2:0] {
        SEL_CTRL = 3'b000,
        SEL_COUNT = 3'b001,
        SEL_RELOAD = 3'b010,
        SEL_STATUS = 3'b011,
        SEL_NONE = 3'b100
    } regsel_e;
endpackage : timer_pkg

// ### hdl/prescale_divider.sv
// prescaler: one-cycle tick every 2**sel system clocks
// assumes enable comes from a register on the same clock
`timescale 1ns/1ps
module prescale_divider (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic enable, // timer running
    input wire logic [timer_pkg::PRE_W-1:0] preSel, // divide select
    output logic tick // one-cycle count pulse
);
    import timer_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
    } state_s;

    state_s st_ff;
    state_s nxt_st;
    logic [DIV_W-1:0] limit;

    // terminal value is the divisor minus one
    assign limit = DIV_W'((8'h01 << preSel) - 8'h01);
    assign tick = enable && (st_ff.cnt == limit);

    // restart on disable so the first tick is a full period away
    always_comb begin
        nxt_st = st_ff;
        if (!enable || tick) begin
            nxt_st.cnt = '0;
        end else begin
            nxt_st.cnt = st_ff.cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : prescale_divider

// ### hdl/reload_timer.sv
// 16-bit reload timer, one-shot and continuous modes, AXI4-Lite slave
// assumes one system clock, synchronous reset and a well-behaved master
// Function
// - sixteen-bit counter steps by one per prescaled tick while enabled.
// - prescaler divides the system clock by 1 up to 128.
// - count FFFFh wraps to 0000h and keeps counting silently.
// - reload 0001h with prescale 1 gives the shortest time-out.
// - reload 0000h with prescale 128 gives the longest, after wrapping.
// - these modes always count the prescaled clock, never the pin.
// - one-shot match raises interrupt request and restarts count at 0001h.
// - one-shot match clears the enable bit and stops counting.
// - one-shot output inverts for exactly one clock at the match.
// - one-shot time-out is reload minus start plus one, times prescale.
// - continuous match raises request, restarts at 0001h, keeps running.
// - continuous output toggles at each match and holds between.
// - written start count only shapes the first continuous pass.
// - later continuous periods last reload times prescale clocks.
// - output starts at the programmed polarity level before counting.
`timescale 1ns/1ps
module reload_timer #(
    parameter int ADDR_W = 8 // AXI address width
) (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic [ADDR_W-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [timer_pkg::DATA_W-1:0] wdata, // write data
    input wire logic [timer_pkg::STRB_W-1:0] wstrb, // byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [ADDR_W-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [timer_pkg::DATA_W-1:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic timerIrq, // one-cycle reload request
    output logic timerOut, // timer output pin level
    output logic timerOutEn // timer output pin enable
);
    import timer_pkg::*;

    // register map, one aligned word each:
    //   0x00 control: bit 0 enable, bit 1 mode, bits 4:2 prescale,
    //        bit 5 output_polarity_bit, bit 6 pin enable
    //   0x04 count: running count, a write sets the start
    //   0x08 reload: match value, zero means a 65536-step pass
    //   0x0C status: bit 0 seen (write 1 clears), bit 1 running
    //   other addresses answer with an error and store nothing
    // bus timing seen from the master:
    //   write answer one cycle after both halves are in
    //   read answer one cycle after the address is taken
    //   address and data may come in either order
    //   a held half waits, its ready low, for the other
    //   readies drop while an answer waits
    //   one write and one read under way at most
    //   unused bits read as zero
    //   read data are the registers at the address edge
    // timer timing:
    //   first tick one full prescale period after enable
    //   prescale 2**s: one tick in every 2**s cycles
    //   a tick finding count equal to reload is the event
    //   the event restarts the count at 0001h
    //   request and pin change one cycle after the event
    //   one-shot clears enable on the event edge
    //   a one-shot restart needs only a new enable
    // limitations a user must know:
    //   one-shot runs one prescale period past reload-start,
    //   since the event waits for the tick after the match
    //   later continuous periods are reload times prescale
    //   a count write while running can skip a match
    //   a control write in the event cycle beats auto-disable
    //   no timer input pin; only the prescaled clock counts
    //   the request is a bare pulse with no mask here
    //   start count and reload are not checked together
    //   reset is synchronous and clears every register
    //   readies rise on the first edge after reset
    // hazards and trade-offs:
    //   bus writes follow counting, so software wins a tie
    //   seen is set again after writes: no event is lost
    //   registered readies cost an idle cycle per transfer,
    //     but keep every bus output straight from a flop
    //   a count read returns the value before that tick
    //   prescale changes while running are not blocked;
    //     software should disable first
    //   the prescaler restarts while disabled, so a
    //     re-enable always gives a full first period
    //   pin enable follows its control bit a cycle late,
    //     together with the pin level register
    //   an unmapped write still gets its answer,
    //     so a misaddressed master never hangs
    //   upper strobes are ignored; registers are 16 bits
    //   a control write without strobe 0 is dropped
    //   a zero reload needs a wrap through FFFFh first
    //   a start above reload also wraps before the match
    //   a running count read is not a snapshot

    typedef struct packed {
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [DATA_W-1:0] wData;
        logic [STRB_W-1:0] wStrb;
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [DATA_W-1:0] rData;
        logic [1:0] rResp;
        logic [CTRL_W-1:0] ctrl;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] reload;
        logic seen;
        logic irq;
    } state_s;

    state_s st_ff;
    state_s nxt_st;
    // tick is gated by enable inside the prescaler
    // running mirrors enable; contMode decodes the mode
    logic tick;
    logic running;
    logic reloadHit;
    logic contMode;

    // address decode, shared by the read and write paths
    function automatic regsel_e decodeAddr(input logic [ADDR_W-1:0] a);
        regsel_e sel;
        sel = SEL_NONE;
        if (a == ADDR_W'(OFF_CTRL)) begin
            sel = SEL_CTRL;
        end else if (a == ADDR_W'(OFF_COUNT)) begin
            sel = SEL_COUNT;
        end else if (a == ADDR_W'(OFF_RELOAD)) begin
            sel = SEL_RELOAD;
        end else if (a == ADDR_W'(OFF_STATUS)) begin
            sel = SEL_STATUS;
        end
        return sel;
    endfunction : decodeAddr

    // byte-lane merge for the 16-bit registers
    function automatic logic [CNT_W-1:0] mergeLanes(
        input logic [CNT_W-1:0] old,
        input logic [DATA_W-1:0] data,
        input logic [STRB_W-1:0] strb
    );
        logic [CNT_W-1:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : mergeLanes

    // read mux, unused bits read as zero
    function automatic logic [DATA_W-1:0] readReg(input regsel_e sel, input state_s s);
        logic [DATA_W-1:0] val;
        val = '0;
        case (sel)
            SEL_CTRL: begin
                val[CTRL_W-1:0] = s.ctrl;
            end
            SEL_COUNT: begin
                val[CNT_W-1:0] = s.count;
            end
            SEL_RELOAD: begin
                val[CNT_W-1:0] = s.reload;
            end
            SEL_STATUS: begin
                val[STAT_SEEN] = s.seen;
                val[STAT_RUN] = s.ctrl[CTRL_EN];
            end
            default: begin
                val = '0;
            end
        endcase
        return val;
    endfunction : readReg

    assign running = st_ff.ctrl[CTRL_EN];
    assign contMode = (mode_e'(st_ff.ctrl[CTRL_MODE]) == MODE_CONT);
    // match is taken on the tick that finds count equal to reload
    assign reloadHit = running && tick && (st_ff.count == st_ff.reload);

    // clock source is always the prescaled system clock in these modes
    prescale_divider u_prescale (
        .core_clk(core_clk),
        .reset(reset),
        .enable(running),
        .preSel(st_ff.ctrl[CTRL_PRE_LO +: PRE_W]),
        .tick(tick)
    );

    timer_out_pin u_outpin (
        .core_clk(core_clk),
        .reset(reset),
        .enable(running),
        .contMode(contMode),
        .polarity(st_ff.ctrl[CTRL_POL]),
        .outEnable(st_ff.ctrl[CTRL_OUTEN]),
        .reloadHit(reloadHit),
        .pinLevel(timerOut),
        .pinDrive(timerOutEn)
    );

    // next state: counting first, then bus writes, which win over it except for seen
    always_comb begin
        nxt_st = st_ff;
        nxt_st.irq = 1'b0;

        // count advance and reload handling
        if (reloadHit) begin
            nxt_st.count = COUNT_RESTART;
            nxt_st.irq = 1'b1;
            nxt_st.seen = 1'b1;
            if (!contMode) begin
                nxt_st.ctrl[CTRL_EN] = 1'b0;
            end
        end else if (running && tick) begin
            // natural 16-bit wrap, so a zero reload takes the full range
            nxt_st.count = st_ff.count + COUNT_STEP;
        end

        // write address and data are taken independently
        if (awvalid && st_ff.awReady) begin
            nxt_st.awHeld = 1'b1;
            nxt_st.awAddr = awaddr;
        end
        if (wvalid && st_ff.wReady) begin
            nxt_st.wHeld = 1'b1;
            nxt_st.wData = wdata;
            nxt_st.wStrb = wstrb;
        end

        // both halves present: commit the write, answer next cycle
        if (nxt_st.awHeld && nxt_st.wHeld) begin
            nxt_st.awHeld = 1'b0;
            nxt_st.wHeld = 1'b0;
            nxt_st.bValid = 1'b1;
            nxt_st.bResp = RESP_OKAY;
            case (decodeAddr(nxt_st.awAddr))
                SEL_CTRL: begin
                    if (nxt_st.wStrb[0]) begin
                        nxt_st.ctrl = nxt_st.wData[CTRL_W-1:0];
                    end
                end
                SEL_COUNT: begin
                    // sets the count at once, mid-pass too, and wins over a same-cycle restart
                    nxt_st.count = mergeLanes(st_ff.count, nxt_st.wData, nxt_st.wStrb);
                end
                SEL_RELOAD: begin
                    nxt_st.reload = mergeLanes(st_ff.reload, nxt_st.wData, nxt_st.wStrb);
                end
                SEL_STATUS: begin
                    if (nxt_st.wStrb[0] && nxt_st.wData[STAT_SEEN]) begin
                        nxt_st.seen = 1'b0;
                    end
                end
                default: begin
                    nxt_st.bResp = RESP_SLVERR;
                end
            endcase
        end

        // a reload in the clearing cycle is not lost
        if (reloadHit) begin
            nxt_st.seen = 1'b1;
        end

        // write response handshake
        if (st_ff.bValid && bready) begin
            nxt_st.bValid = 1'b0;
        end
        // one write in flight: stall new halves until the answer is gone
        nxt_st.awReady = !nxt_st.awHeld && !nxt_st.bValid;
        nxt_st.wReady = !nxt_st.wHeld && !nxt_st.bValid;

        // read channel, data one cycle after the address is taken
        if (st_ff.rValid && rready) begin
            nxt_st.rValid = 1'b0;
        end
        if (arvalid && st_ff.arReady) begin
            nxt_st.rValid = 1'b1;
            nxt_st.rData = readReg(decodeAddr(araddr), st_ff);
            if (decodeAddr(araddr) == SEL_NONE) begin
                nxt_st.rResp = RESP_SLVERR;
            end else begin
                nxt_st.rResp = RESP_OKAY;
            end
        end
        nxt_st.arReady = !nxt_st.rValid;
    end

    // state register
    // struct cleared first, then each register takes its
    // package reset, so the branch holds only constants
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.ctrl <= CTRL_RST;
            st_ff.count <= COUNT_RST;
            st_ff.reload <= RELOAD_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // pin level and enable come from flops in the pin helper
    // all bus outputs and the request come straight from the register
    assign awready = st_ff.awReady;
    assign wready = st_ff.wReady;
    assign bvalid = st_ff.bValid;
    assign bresp = st_ff.bResp;
    assign arready = st_ff.arReady;
    assign rvalid = st_ff.rValid;
    assign rdata = st_ff.rData;
    assign rresp = st_ff.rResp;
    assign timerIrq = st_ff.irq;
endmodule : reload_timer

// ### hdl/timer_out_pin.sv
// timer output pin: toggles in continuous mode, flashes in one-shot
// assumes reloadHit is a one-cycle pulse on the same clock
`timescale 1ns/1ps
module timer_out_pin (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic enable, // timer running
    input wire logic contMode, // 1 continuous, 0 one-shot
    input wire logic polarity, // output_polarity_bit
    input wire logic outEnable, // alternate function on
    input wire logic reloadHit, // reload event pulse
    output logic pinLevel, // pin level
    output logic pinDrive // pin output enable
);
    import timer_pkg::*;

    typedef struct packed {
        logic level;
        logic pin;
        logic drive;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // held level starts from the polarity bit while stopped
    always_comb begin
        nxt_st = st_ff;
        if (!enable && !reloadHit) begin
            nxt_st.level = polarity;
        end else if (reloadHit && contMode) begin
            nxt_st.level = !st_ff.level;
        end
        // one-shot inverts the polarity level for the event cycle only
        if (contMode) begin
            nxt_st.pin = nxt_st.level;
        end else begin
            nxt_st.pin = polarity ^ reloadHit;
        end
        nxt_st.drive = outEnable;
        if (!outEnable) begin
            nxt_st.pin = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pinLevel = st_ff.pin;
    assign pinDrive = st_ff.drive;
endmodule : timer_out_pin

// ### test/axil_master.sv
// AXI4-Lite master model standing in for the CPU
// assumes wr and rd are called one at a time from one process
`timescale 1ns/1ps
module axil_master (
    input wire logic core_clk, // clk
    output logic [7:0] awaddr, // aw addr
    output logic awvalid, // aw valid
    input wire logic awready, // aw ready
    output logic [timer_pkg::DATA_W-1:0] wdata, // w data
    output logic [timer_pkg::STRB_W-1:0] wstrb, // strobes
    output logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic [1:0] bresp, // b resp
    input wire logic bvalid, // b valid
    output logic bready, // b ready
    output logic [7:0] araddr, // ar addr
    output logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic [timer_pkg::DATA_W-1:0] rdata, // r data
    input wire logic [1:0] rresp, // r resp
    input wire logic rvalid, // r valid
    output logic rready // r ready
);
    import timer_pkg::*;
    // idle bus at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
    end
    // released payloads are inverted so a stale value never matches
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge core_clk);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge core_clk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge core_clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : axil_master

// ### test/reload_timer_sva.sv
// port assertions for the reload timer
// assumes control writes carry address and data in one beat
`timescale 1ns/1ps
module reload_timer_sva #(
    parameter int ADDR_W = 8 // addr width
) (
    input wire logic core_clk, // clk
    input wire logic reset, // sync reset
    input wire logic [ADDR_W-1:0] awaddr, // aw addr
    input wire logic awvalid, // aw valid
    input wire logic awready, // aw ready
    input wire logic [timer_pkg::DATA_W-1:0] wdata, // w data
    input wire logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic [1:0] bresp, // b resp
    input wire logic bvalid, // b valid
    input wire logic bready, // b ready
    input wire logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic [timer_pkg::DATA_W-1:0] rdata, // r data
    input wire logic rvalid, // r valid
    input wire logic rready, // r ready
    input wire logic timerIrq, // reload pulse
    input wire logic timerOut, // pin level
    input wire logic timerOutEn // pin enable
);
    import timer_pkg::*;
    logic [CTRL_W-1:0] ctl_ff;
    logic [CTRL_W-1:0] nxt_ctl;
    // shadow control word; lags the hardware auto-disable by one cycle
    always_comb begin
        nxt_ctl = ctl_ff;
        if (timerIrq && !ctl_ff[CTRL_MODE]) nxt_ctl[CTRL_EN] = 1'b0;
        if (awvalid && awready && wvalid && wready && awaddr == OFF_CTRL) nxt_ctl = wdata[CTRL_W-1:0];
    end
    always_ff @(posedge core_clk) begin
        if (reset) ctl_ff <= CTRL_RST;
        else ctl_ff <= nxt_ctl;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_b_latency: assert property (awvalid && awready && wvalid && wready |=> bvalid)
        else $error("write response not one cycle after the beat");
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_r_latency: assert property (arvalid && arready |=> rvalid)
        else $error("read data not one cycle after the address");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed while waiting");
    a_ar_refuse: assert property (rvalid |-> !arready)
        else $error("read address accepted while data pending");
    a_oneshot_single: assert property (timerIrq && !ctl_ff[CTRL_MODE] |=> !timerIrq [*8])
        else $error("one-shot kept counting after its event");
    a_pin_flash: assert property (timerIrq && ctl_ff[CTRL_OUTEN] && !ctl_ff[CTRL_MODE]
        |-> timerOut != $past(timerOut) ##1 timerOut == $past(timerOut, 2))
        else $error("one-shot pin flash wrong");
    a_pin_toggle: assert property (timerIrq && ctl_ff[CTRL_OUTEN] && ctl_ff[CTRL_MODE] && ctl_ff[CTRL_EN]
        |-> timerOut != $past(timerOut) ##1 $stable(timerOut))
        else $error("continuous pin did not toggle and hold");
    a_outen_follow: assert property (timerOutEn == $past(ctl_ff[CTRL_OUTEN]))
        else $error("pin enable does not follow control");
    a_stop_quiet: assert property (!ctl_ff[CTRL_EN] && !$past(ctl_ff[CTRL_EN])
        && !$past(ctl_ff[CTRL_EN], 2) |-> !timerIrq)
        else $error("reload event while disabled");
endmodule : reload_timer_sva
bind reload_timer reload_timer_sva #(.ADDR_W(ADDR_W)) sva (.*);

// ### test/reload_timer_tb_top.sv
// self-checking bench for the reload timer
// assumes the bus model answers every call; a cycle ceiling cuts hangs
`timescale 1ns/1ps
module reload_timer_tb_top;
    import timer_pkg::*;
    `define CHK(a, e) begin nTests++; if ((a) !== (e)) begin errorCnt++; \
        $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
    logic core_clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, timerIrq, timerOut, timerOutEn;
    logic [7:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp;
    int errorCnt = 0;
    int nTests = 0;
    int cyc = 0;
    reload_timer uut (.*);
    axil_master bfm (.*);
    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;
    // hang guard, well above the thirteen hundred or so cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errorCnt++;
            closeOut();
        end
    end
    task automatic closeOut;
        if (errorCnt == 0 && nTests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : closeOut
    task automatic chkRd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        bfm.rd(a, d, r);
        `CHK(d, e)
        `CHK(r, er)
    endtask : chkRd
    // counts edges up to the one that samples the reload pulse
    task automatic waitIrq(input int lim, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (timerIrq !== 1'b1 && n < lim);
    endtask : waitIrq
    // disabled setup, start count, reload, then enable
    task automatic cfg(input logic [6:0] c, input logic [15:0] cnt, input logic [15:0] rl);
        logic [1:0] r;
        bfm.wr(OFF_CTRL, {25'h0, c & 7'h7E}, r);
        bfm.wr(OFF_COUNT, {16'h0, cnt}, r);
        bfm.wr(OFF_RELOAD, {16'h0, rl}, r);
        bfm.wr(OFF_CTRL, {25'h0, c}, r);
    endtask : cfg
    task automatic tcRegs;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) chkRd(8'(4 * i), 32'h0, RESP_OKAY);
        chkRd(8'h10, 32'h0, RESP_SLVERR);
        bfm.wr(8'h10, 32'hFFFF, r);
        `CHK(r, RESP_SLVERR)
        bfm.wr(OFF_RELOAD, 32'h1234ABCD, r);
        chkRd(OFF_RELOAD, 32'hABCD, RESP_OKAY);
    endtask : tcRegs
    // every prescale; start count equal to reload shortens only pass one
    task automatic tcCont;
        int n;
        logic [1:0] r;
        for (int s = 0; s < 8; s++) begin
            cfg({2'b11, 3'(s), 2'b11}, 16'h0003, 16'h0003);
            waitIrq(400, n);
            `CHK(1'(n <= (1 << s) + 3), 1'b1)
            `CHK(timerOut, 1'b0)
            waitIrq(2000, n);
            `CHK(n, 3 * (1 << s))
            `CHK(timerOut, 1'b1)
            `CHK(timerOutEn, 1'b1)
        end
        chkRd(OFF_STATUS, 32'h3, RESP_OKAY);
        bfm.wr(OFF_CTRL, 32'h0, r);
    endtask : tcCont
    task automatic tcOneShot;
        int n;
        logic [1:0] r;
        cfg(7'h45, 16'h0002, 16'h0006);
        bfm.wr(OFF_CTRL, 32'h65, r);
        waitIrq(100, n);
        `CHK(1'(n <= 12), 1'b1)
        `CHK(timerOut, 1'b0)
        chkRd(OFF_CTRL, 32'h64, RESP_OKAY);
        chkRd(OFF_COUNT, 32'h1, RESP_OKAY);
        waitIrq(40, n);
        `CHK(n, 40)
        `CHK(timerOut, 1'b1)
    endtask : tcOneShot
    // shortest setting, then a pass through the wrap to reload zero
    task automatic tcEdges;
        int n;
        logic [1:0] r;
        cfg(7'h01, 16'h0001, 16'h0001);
        waitIrq(20, n);
        `CHK(1'(n <= 3), 1'b1)
        cfg(7'h03, 16'hFFFE, 16'h0000);
        waitIrq(20, n);
        `CHK(1'(n <= 5), 1'b1)
        bfm.wr(OFF_CTRL, 32'h0, r);
        chkRd(OFF_STATUS, 32'h1, RESP_OKAY);
        bfm.wr(OFF_STATUS, 32'h1, r);
        chkRd(OFF_STATUS, 32'h0, RESP_OKAY);
    endtask : tcEdges
    initial begin
        reset = 1'b1;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        tcRegs();
        tcCont();
        tcOneShot();
        tcEdges();
        closeOut();
    end
endmodule : reload_timer_tb_top
